// File: inc/dlyg_pkg.sv
// dlyg_pkg: constants, codes and carrier types of the remote gpio port.
// assumes a 50 MHz system clock and a 32-bit avalon-mm register bus.
//
// Behaviour
// - eight inputs, eight outputs, each assignable to one function or none.
// - one function on several lines; every such line acts alike, independently.
// - button-named input acts exactly like one button press per pulse.
// - build input: first pulse ramps, second asks instant, third confirms fill.
// - ramp/instant fill, ramp/instant drain and bypass inputs act without confirmation.
// - trigger outputs give one 250 ms pulse per state arrival, never repeated.
// - trigger pulses on fill command, on reaching target, on reaching zero.
// - at-target and at-zero outputs show those conditions continuously.
// - lamp outputs low while lamp lit, high while dark, following flashes.
// - building and exiting outputs held low during that state, else high.
// - cue or flag input is stored with the audio sample arriving then.
// - eight independent cue points and eight flag points, on inputs and outputs.
// - cue mark leaving the delay gives 250 ms pulse on its outputs.
// - flag level stored with audio is reproduced as samples leave delay.
// - global enable off makes all inputs ignored.
// - test mode shows each input as 1 while a trigger is present.
// - test mode sets any single output to 1 or 0, overriding function.
// - leaving test mode forces all eight outputs to 0 for one cycle.
package dlyg_pkg;

    // timing
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned PULSE_MS     = 250;
    localparam int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000);

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_TEST_OUT = 8'h08;
    localparam logic [2:0] BLK_IN_SEL    = 3'h1;
    localparam logic [2:0] BLK_OUT_SEL   = 3'h2;

    // field positions
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_TEST_BIT = 1;
    localparam int unsigned STAT_OUT_LSB  = 8;
    localparam int unsigned STAT_BLD_LSB  = 16;

    // reset values
    localparam logic       CTRL_EN_RST   = 1'h1;
    localparam logic [7:0] SEL_RST       = 8'h00;
    localparam logic [7:0] TEST_OUT_RST  = 8'h00;

    typedef enum logic [3:0] {
        IN_NONE       = 4'h0,
        IN_BUILD      = 4'h1,
        IN_FILL_RAMP  = 4'h2,
        IN_FILL_NOW   = 4'h3,
        IN_EXIT       = 4'h4,
        IN_DRAIN_RAMP = 4'h5,
        IN_DRAIN_NOW  = 4'h6,
        IN_BYPASS     = 4'h7,
        IN_CUE        = 4'h8,
        IN_FLAG       = 4'h9
    } dlyg_in_func_type;

    typedef enum logic [3:0] {
        OUT_NONE        = 4'h0,
        OUT_BUILD_LAMP  = 4'h1,
        OUT_BUILDING    = 4'h2,
        OUT_EXIT_LAMP   = 4'h3,
        OUT_EXITING     = 4'h4,
        OUT_FILL_TRIG   = 4'h5,
        OUT_TARGET_TRIG = 4'h6,
        OUT_ZERO_TRIG   = 4'h7,
        OUT_AT_TARGET   = 4'h8,
        OUT_AT_ZERO     = 4'h9,
        OUT_BYPASS      = 4'hA,
        OUT_CUE         = 4'hB,
        OUT_FLAG        = 4'hC
    } dlyg_out_func_type;

    typedef enum logic [2:0] {
        BLD_IDLE = 3'b001,
        BLD_RAMP = 3'b010,
        BLD_ASK  = 3'b100
    } dlyg_bld_state_type;

    // one line's assignment: point index and function code
    typedef struct packed {
        logic       spare;
        logic [2:0] idx;
        logic [3:0] func;
    } dlyg_sel_type;

    // state of the delay engine seen by the port
    typedef struct packed {
        logic build_lamp;
        logic exit_lamp;
        logic bypass_lamp;
        logic building;
        logic exiting;
        logic at_target;
        logic at_zero;
    } dlyg_engine_type;

    // one-cycle commands to the delay engine
    typedef struct packed {
        logic fill_ramp;
        logic fill_ask;
        logic fill_now;
        logic exit_press;
        logic drain_ramp;
        logic drain_now;
        logic bypass_press;
    } dlyg_cmd_type;

    // marks that travel with one audio sample
    typedef struct packed {
        logic [7:0] flag;
        logic [7:0] cue;
    } dlyg_marks_type;

endpackage

// File: verilog/dlyg_pulse_stretch.sv
// dlyg_pulse_stretch: one fixed-length pulse per rising edge of a trigger.
// assumes trigger synchronous to clk; edges during a running pulse are dropped.
`timescale 1ns/10ps
module dlyg_pulse_stretch #(
    parameter int unsigned CYCLES = dlyg_pkg::PULSE_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // trigger and pulse
    input  wire logic trig_i,
    output logic      pulse_o
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic          trig_q;
    logic          trig_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          pulse_q;
    logic          pulse_d;

    always_comb begin
        trig_d  = trig_i;
        cnt_d   = cnt_q;
        // not retriggered while running nor while the state persists
        if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end else if (trig_i && !trig_q) begin
            cnt_d = LOAD;
        end
        pulse_d = (cnt_d != '0);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_q  <= 1'b0;
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            trig_q  <= trig_d;
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_o = pulse_q;

endmodule // dlyg_pulse_stretch

// File: verilog/dlyg_remote_port.sv
// dlyg_remote_port: eight-in, eight-out programmable remote port with test mode.
// assumes gpi_i synchronous to clk_sys_i, active high while a closure is made,
// and a delay memory that stores mark_wr_o with each sample at sample_tick_i.
`timescale 1ns/10ps
module dlyg_remote_port #(
    parameter int unsigned PULSE_CYCLES = dlyg_pkg::PULSE_CYCLES,
    parameter int unsigned LINES        = 8,
    parameter int unsigned POINTS       = 8
) (
    // clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_b_i,
    // avalon-mm slave
    input  wire logic [7:0]               avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    // remote pins
    input  wire logic [LINES-1:0]         gpi_i,
    output logic      [LINES-1:0]         gpo_o,
    // delay engine
    input  wire dlyg_pkg::dlyg_engine_type engine_i,
    output dlyg_pkg::dlyg_cmd_type        cmd_o,
    // marks to and from the delay memory
    input  wire logic                     sample_tick_i,
    output dlyg_pkg::dlyg_marks_type      mark_wr_o,
    input  wire logic                     out_tick_i,
    input  wire dlyg_pkg::dlyg_marks_type mark_rd_i
);
    localparam int unsigned NTRIG = 3 + POINTS;

    // reset release
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // registers
    logic                        en_q, en_d;
    logic                        test_q, test_d;
    logic [LINES-1:0]            test_out_q, test_out_d;
    dlyg_pkg::dlyg_sel_type      in_sel_q [LINES];
    dlyg_pkg::dlyg_sel_type      in_sel_d [LINES];
    dlyg_pkg::dlyg_sel_type      out_sel_q [LINES];
    dlyg_pkg::dlyg_sel_type      out_sel_d [LINES];
    logic                        wait_q, wait_d;
    logic [31:0]                 rdata_q, rdata_d;

    // datapath state
    logic [LINES-1:0]            gpi_q, gpi_prev_q;
    logic [LINES-1:0]            gpi_rise;
    dlyg_pkg::dlyg_bld_state_type bld_q, bld_d;
    dlyg_pkg::dlyg_cmd_type      cmd_q, cmd_d;
    logic [POINTS-1:0]           cue_pend_q, cue_pend_d;
    dlyg_pkg::dlyg_marks_type    mark_q, mark_d;
    logic [POINTS-1:0]           flag_out_q, flag_out_d;
    logic [LINES-1:0]            gpo_q, gpo_d;
    logic [NTRIG-1:0]            trig_src;
    logic [NTRIG-1:0]            trig_pulse;

    // presses gathered over all lines
    logic                        p_build, p_fill_ramp, p_fill_now, p_exit;
    logic                        p_drain_ramp, p_drain_now, p_bypass;
    logic [POINTS-1:0]           cue_set;
    logic [POINTS-1:0]           flag_lvl;

    // bus access: one wait cycle, then the answer
    logic        acc_go;
    logic        wr_go;
    logic [2:0]  blk;
    logic [2:0]  sel_idx;

    assign acc_go  = (avs_read_i || avs_write_i) && !wait_q;
    assign wr_go   = avs_write_i && !wait_q;
    assign blk     = avs_address_i[7:5];
    assign sel_idx = avs_address_i[4:2];

    always_comb begin
        en_d       = en_q;
        test_d     = test_q;
        test_out_d = test_out_q;
        for (int i = 0; i < LINES; i++) begin
            in_sel_d[i]  = in_sel_q[i];
            out_sel_d[i] = out_sel_q[i];
        end
        wait_d  = !((avs_read_i || avs_write_i) && wait_q);
        rdata_d = rdata_q;
        if ((avs_read_i || avs_write_i) && wait_q) begin
            rdata_d = 32'h0000_0000;
            if (avs_address_i == dlyg_pkg::ADDR_CTRL) begin
                rdata_d[dlyg_pkg::CTRL_EN_BIT]   = en_q;
                rdata_d[dlyg_pkg::CTRL_TEST_BIT] = test_q;
            end else if (avs_address_i == dlyg_pkg::ADDR_STATUS) begin
                rdata_d[LINES-1:0] = gpi_q;
                rdata_d[dlyg_pkg::STAT_OUT_LSB +: LINES] = gpo_q;
                rdata_d[dlyg_pkg::STAT_BLD_LSB +: 3]     = bld_q;
            end else if (avs_address_i == dlyg_pkg::ADDR_TEST_OUT) begin
                rdata_d[LINES-1:0] = test_out_q;
            end else if (blk == dlyg_pkg::BLK_IN_SEL && avs_address_i[1:0] == 2'h0) begin
                rdata_d[7:0] = in_sel_q[sel_idx];
            end else if (blk == dlyg_pkg::BLK_OUT_SEL && avs_address_i[1:0] == 2'h0) begin
                rdata_d[7:0] = out_sel_q[sel_idx];
            end
        end
        if (wr_go && avs_byteenable_i[0]) begin
            if (avs_address_i == dlyg_pkg::ADDR_CTRL) begin
                en_d   = avs_writedata_i[dlyg_pkg::CTRL_EN_BIT];
                test_d = avs_writedata_i[dlyg_pkg::CTRL_TEST_BIT];
            end else if (avs_address_i == dlyg_pkg::ADDR_TEST_OUT) begin
                test_out_d = avs_writedata_i[LINES-1:0];
            end else if (blk == dlyg_pkg::BLK_IN_SEL && avs_address_i[1:0] == 2'h0) begin
                in_sel_d[sel_idx] = avs_writedata_i[7:0];
            end else if (blk == dlyg_pkg::BLK_OUT_SEL && avs_address_i[1:0] == 2'h0) begin
                out_sel_d[sel_idx] = avs_writedata_i[7:0];
            end
        end
        // test pattern dropped on leaving, so the pins restart from zero
        if (test_q && !test_d) begin
            test_out_d = dlyg_pkg::TEST_OUT_RST;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            en_q       <= dlyg_pkg::CTRL_EN_RST;
            test_q     <= 1'b0;
            test_out_q <= dlyg_pkg::TEST_OUT_RST;
            for (int i = 0; i < LINES; i++) begin
                in_sel_q[i]  <= dlyg_pkg::SEL_RST;
                out_sel_q[i] <= dlyg_pkg::SEL_RST;
            end
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            en_q       <= en_d;
            test_q     <= test_d;
            test_out_q <= test_out_d;
            for (int i = 0; i < LINES; i++) begin
                in_sel_q[i]  <= in_sel_d[i];
                out_sel_q[i] <= out_sel_d[i];
            end
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // input edges; a held closure is one press only
    assign gpi_rise = gpi_q & ~gpi_prev_q & {LINES{en_q}};

    always_comb begin
        p_build      = 1'b0;
        p_fill_ramp  = 1'b0;
        p_fill_now   = 1'b0;
        p_exit       = 1'b0;
        p_drain_ramp = 1'b0;
        p_drain_now  = 1'b0;
        p_bypass     = 1'b0;
        cue_set      = '0;
        flag_lvl     = '0;
        // lines sharing a function are simply or-ed
        for (int i = 0; i < LINES; i++) begin
            case (in_sel_q[i].func)
                dlyg_pkg::IN_BUILD:      p_build      = p_build | gpi_rise[i];
                dlyg_pkg::IN_FILL_RAMP:  p_fill_ramp  = p_fill_ramp | gpi_rise[i];
                dlyg_pkg::IN_FILL_NOW:   p_fill_now   = p_fill_now | gpi_rise[i];
                dlyg_pkg::IN_EXIT:       p_exit       = p_exit | gpi_rise[i];
                dlyg_pkg::IN_DRAIN_RAMP: p_drain_ramp = p_drain_ramp | gpi_rise[i];
                dlyg_pkg::IN_DRAIN_NOW:  p_drain_now  = p_drain_now | gpi_rise[i];
                dlyg_pkg::IN_BYPASS:     p_bypass     = p_bypass | gpi_rise[i];
                dlyg_pkg::IN_CUE:        cue_set[in_sel_q[i].idx] = 1'b1 & gpi_rise[i]
                                                        | cue_set[in_sel_q[i].idx];
                dlyg_pkg::IN_FLAG:       flag_lvl[in_sel_q[i].idx] = (gpi_q[i] & en_q)
                                                        | flag_lvl[in_sel_q[i].idx];
                default: ;
            endcase
        end
    end

    // build button sequence and engine commands
    always_comb begin
        bld_d              = bld_q;
        cmd_d              = '0;
        cmd_d.fill_ramp    = p_fill_ramp;
        cmd_d.fill_now     = p_fill_now;
        cmd_d.exit_press   = p_exit;
        cmd_d.drain_ramp   = p_drain_ramp;
        cmd_d.drain_now    = p_drain_now;
        cmd_d.bypass_press = p_bypass;
        unique case (bld_q)
            dlyg_pkg::BLD_IDLE: begin
                if (p_build) begin
                    cmd_d.fill_ramp = 1'b1;
                    bld_d           = dlyg_pkg::BLD_RAMP;
                end
            end
            dlyg_pkg::BLD_RAMP: begin
                if (p_build) begin
                    cmd_d.fill_ask = 1'b1;
                    bld_d          = dlyg_pkg::BLD_ASK;
                end else if (engine_i.at_target || engine_i.exiting) begin
                    bld_d = dlyg_pkg::BLD_IDLE;
                end
            end
            dlyg_pkg::BLD_ASK: begin
                if (p_build) begin
                    cmd_d.fill_now = 1'b1;
                    bld_d          = dlyg_pkg::BLD_IDLE;
                end else if (engine_i.at_target || engine_i.exiting) begin
                    bld_d = dlyg_pkg::BLD_IDLE;
                end
            end
            default: bld_d = dlyg_pkg::BLD_IDLE;
        endcase
    end

    // marks: a cue waits for the next sample; set beats the clear
    always_comb begin
        cue_pend_d = (sample_tick_i ? '0 : cue_pend_q) | cue_set;
        mark_d.cue  = cue_pend_d;
        mark_d.flag = flag_lvl;
        flag_out_d  = out_tick_i ? mark_rd_i.flag : flag_out_q;
    end

    // trigger sources, each stretched to one long pulse
    always_comb begin
        trig_src[0] = cmd_q.fill_ramp | cmd_q.fill_now;
        trig_src[1] = engine_i.at_target;
        trig_src[2] = engine_i.at_zero;
        for (int c = 0; c < POINTS; c++) begin
            trig_src[3 + c] = out_tick_i & mark_rd_i.cue[c];
        end
    end

    for (genvar t = 0; t < NTRIG; t++) begin : g_trig
        dlyg_pulse_stretch #(
            .CYCLES    (PULSE_CYCLES)
        ) u_stretch (
            .clk_sys_i (clk_sys_i),
            .rst_b_i   (rst_sync_q),
            .trig_i    (trig_src[t]),
            .pulse_o   (trig_pulse[t])
        );
    end

    // output pins
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            case (out_sel_q[i].func)
                dlyg_pkg::OUT_BUILD_LAMP:  gpo_d[i] = ~engine_i.build_lamp;
                dlyg_pkg::OUT_EXIT_LAMP:   gpo_d[i] = ~engine_i.exit_lamp;
                dlyg_pkg::OUT_BYPASS:      gpo_d[i] = ~engine_i.bypass_lamp;
                dlyg_pkg::OUT_BUILDING:    gpo_d[i] = ~engine_i.building;
                dlyg_pkg::OUT_EXITING:     gpo_d[i] = ~engine_i.exiting;
                dlyg_pkg::OUT_FILL_TRIG:   gpo_d[i] = trig_pulse[0];
                dlyg_pkg::OUT_TARGET_TRIG: gpo_d[i] = trig_pulse[1];
                dlyg_pkg::OUT_ZERO_TRIG:   gpo_d[i] = trig_pulse[2];
                dlyg_pkg::OUT_AT_TARGET:   gpo_d[i] = engine_i.at_target;
                dlyg_pkg::OUT_AT_ZERO:     gpo_d[i] = engine_i.at_zero;
                dlyg_pkg::OUT_CUE:   gpo_d[i] = trig_pulse[3 + out_sel_q[i].idx];
                dlyg_pkg::OUT_FLAG:  gpo_d[i] = flag_out_q[out_sel_q[i].idx];
                default:                   gpo_d[i] = 1'b0;
            endcase
        end
        if (test_q) begin
            gpo_d = test_out_q;
        end
        // one cycle of all-zero on the way out of test mode
        if (test_q && !test_d) begin
            gpo_d = '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            gpi_q      <= '0;
            gpi_prev_q <= '0;
            bld_q      <= dlyg_pkg::BLD_IDLE;
            cmd_q      <= '0;
            cue_pend_q <= '0;
            mark_q     <= '0;
            flag_out_q <= '0;
            gpo_q      <= '0;
        end else begin
            gpi_q      <= gpi_i;
            gpi_prev_q <= gpi_q;
            bld_q      <= bld_d;
            cmd_q      <= cmd_d;
            cue_pend_q <= cue_pend_d;
            mark_q     <= mark_d;
            flag_out_q <= flag_out_d;
            gpo_q      <= gpo_d;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign gpo_o             = gpo_q;
    assign cmd_o             = cmd_q;
    assign mark_wr_o         = mark_q;

endmodule // dlyg_remote_port

// File: testbench/dlyg_remote_port_properties.sv
// checker: bus handshake and command pulses of the remote port.
// assumes it sees only the top module's ports, bound from the bench.
`timescale 1ns/10ps
module dlyg_remote_port_properties (
    // watched ports
    input wire logic                   clk_sys_i,
    input wire logic                   rst_b_i,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic [31:0]            avs_readdata_o,
    input wire logic                   avs_waitrequest_o,
    input wire logic [7:0]             gpi_i,
    input wire dlyg_pkg::dlyg_cmd_type cmd_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    wire logic req = avs_read_i || avs_write_i;
    property p_sync; $rose(rst_b_i) |-> avs_waitrequest_o [*2]; endproperty
    property p_answer; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    property p_once; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    property p_idle; !req |=> avs_waitrequest_o; endproperty
    property p_hold; !req && avs_waitrequest_o |=> $stable(avs_readdata_o); endproperty
    // a command needs a fresh closure two edges back
    property p_cause;
        (cmd_o != 7'h00) |-> (($past(gpi_i, 2) & ~$past(gpi_i, 3)) != 8'h00);
    endproperty
    property p_gap; (cmd_o != 7'h00) |=> ((cmd_o & $past(cmd_o)) == 7'h00); endproperty
    property p_build; $onehot0({cmd_o.fill_ramp, cmd_o.fill_ask, cmd_o.fill_now}); endproperty
    a_sync: assert property (p_sync) else $error("bus busy too short after reset");
    a_answer: assert property (p_answer) else $error("no answer one cycle on");
    a_once: assert property (p_once) else $error("answer held too long");
    a_idle: assert property (p_idle) else $error("wait low while idle");
    a_hold: assert property (p_hold) else $error("read data moved while idle");
    a_cause: assert property (p_cause) else $error("command without closure");
    a_gap: assert property (p_gap) else $error("command longer than one cycle");
    a_build: assert property (p_build) else $error("two build steps at once");
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
    c_now: cover property (cmd_o.fill_now);
    c_bypass: cover property (cmd_o.bypass_press);
endmodule // dlyg_remote_port_properties

// File: testbench/dlyg_remote_model.sv
// remote panel model: momentary closures on the eight input lines.
// assumes one task call at a time from the bench.
`timescale 1ns/10ps
module dlyg_remote_model (
    // clock
    input  wire logic       clk_sys_i,
    // closures, active high
    output logic      [7:0] gpi_o
);
    initial gpi_o = 8'h00;
    task automatic hold(input logic [7:0] m);
        @(posedge clk_sys_i);
        gpi_o <= m;
    endtask
    // random hold time, so prompt and slow closures both occur
    task automatic press(input logic [7:0] m);
        hold(m);
        repeat (1 + $urandom_range(4)) @(posedge clk_sys_i);
        gpi_o <= 8'h00;
        repeat (2) @(posedge clk_sys_i);
    endtask
endmodule // dlyg_remote_model

// File: testbench/dlyg_remote_port_tb.sv
// bench of the remote port: bus setup, presses, outputs, test mode, marks.
// assumes short pulses via PULSE_CYCLES and the remote model on the inputs.
`timescale 1ns/10ps
module dlyg_remote_port_tb;
    localparam int unsigned PC = 20;
    logic                     clk_sys_i = 1'b0;
    logic                     rst_b_i = 1'b0;
    logic [7:0]               avs_address_i = 8'h00;
    logic                     avs_read_i = 1'b0;
    logic                     avs_write_i = 1'b0;
    logic [31:0]              avs_writedata_i = 32'h0;
    logic [31:0]              avs_readdata_o;
    logic                     avs_waitrequest_o;
    wire logic [7:0]          gpi_i;
    logic [7:0]               gpo_o;
    dlyg_pkg::dlyg_engine_type engine_i = '0;
    dlyg_pkg::dlyg_cmd_type   cmd_o;
    logic                     sample_tick_i = 1'b0;
    logic                     out_tick_i = 1'b0;
    dlyg_pkg::dlyg_marks_type mark_wr_o;
    dlyg_pkg::dlyg_marks_type mark_rd_i = '0;
    logic [6:0]               seen = 7'h00;
    logic [31:0]              q;
    logic [7:0]               pat;
    int                       hits = 0, failures = 0, checks = 0, cyc = 0, n;
    logic [3:0] ifn [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h7, 4'h4};
    logic [3:0] ofn [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'h0};
    logic [7:0] msk [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h60, 8'h80};
    logic [6:0] exc [6] = '{7'h40, 7'h10, 7'h04, 7'h02, 7'h01, 7'h08};
    dlyg_remote_port #(.PULSE_CYCLES(PC)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .gpi_i(gpi_i), .gpo_o(gpo_o), .engine_i(engine_i), .cmd_o(cmd_o),
        .sample_tick_i(sample_tick_i), .mark_wr_o(mark_wr_o), .out_tick_i(out_tick_i),
        .mark_rd_i(mark_rd_i));
    dlyg_remote_model rm (.clk_sys_i(clk_sys_i), .gpi_o(gpi_i));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    task automatic conclude();
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cmd_o != 7'h00) begin
            seen <= seen | cmd_o;
            hits <= hits + 1;
        end
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic clr();
        @(posedge clk_sys_i);
        seen <= 7'h00;
        hits <= 0;
    endtask
    task automatic pr(input logic [7:0] m, input logic [6:0] e);
        clr();
        rm.press(m);
        repeat (4) @(posedge clk_sys_i);
        check(seen, e);
        check(hits, e != 7'h00);
    endtask
    task automatic cnt(input int b);
        n = 0;
        repeat (60) begin
            @(posedge clk_sys_i);
            n += (gpo_o[b] === 1'b1);
        end
    endtask
    function automatic logic lvl(input logic [3:0] f, input dlyg_pkg::dlyg_engine_type e);
        case (f)
            4'h1: return !e.build_lamp;
            4'h2: return !e.building;
            4'h3: return !e.exit_lamp;
            4'h4: return !e.exiting;
            4'h8: return e.at_target;
            4'h9: return e.at_zero;
            4'hA: return !e.bypass_lamp;
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        void'($urandom(32'hbca6));
        repeat (5) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        bus(0, dlyg_pkg::ADDR_CTRL, 32'h0);
        check(q, 32'h1);
        bus(1, 8'h10, 32'hFF);
        bus(0, 8'h10, 32'h0);
        check(q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bus(1, 8'(8'h20 + 4 * i), {28'h0, ifn[i]});
            bus(1, 8'(8'h40 + 4 * i), {28'h0, ofn[i]});
        end
        bus(0, 8'h3C, 32'h0);
        check(q, 32'h4);
        pr(8'h01, 7'h40);
        pr(8'h01, 7'h20);
        pr(8'h01, 7'h10);
        bus(0, dlyg_pkg::ADDR_STATUS, 32'h0);
        check(q[18:16], 3'b001);
        for (int i = 0; i < 6; i++) pr(msk[i], exc[i]);
        bus(1, dlyg_pkg::ADDR_CTRL, 32'h0);
        clr();
        rm.hold(8'hFF);
        bus(0, dlyg_pkg::ADDR_STATUS, 32'h0);
        check(q[7:0], 8'hFF);
        rm.hold(8'h00);
        repeat (4) @(posedge clk_sys_i);
        check(seen, 7'h00);
        bus(1, dlyg_pkg::ADDR_CTRL, 32'h1);
        repeat (16) begin
            @(posedge clk_sys_i);
            engine_i <= 7'($urandom);
            repeat (3) @(posedge clk_sys_i);
            for (int b = 0; b < 8; b++) check(gpo_o[b], lvl(ofn[b], engine_i));
        end
        for (int k = 0; k < 2; k++) begin
            engine_i <= '0;
            bus(1, 8'h5C, k ? 32'h7 : 32'h6);
            repeat (PC) @(posedge clk_sys_i);
            engine_i <= k ? 7'h01 : 7'h02;
            cnt(7);
            check(n, PC);
        end
        bus(1, dlyg_pkg::ADDR_CTRL, 32'h3);
        pat = 8'($urandom) | 8'h01;
        bus(1, dlyg_pkg::ADDR_TEST_OUT, {24'h0, pat});
        repeat (3) @(posedge clk_sys_i);
        check(gpo_o, pat);
        bus(1, dlyg_pkg::ADDR_CTRL, 32'h1);
        n = 0;
        repeat (3) begin
            @(posedge clk_sys_i);
            n += (gpo_o === 8'h00);
        end
        check(n != 0, 1'b1);
        bus(0, dlyg_pkg::ADDR_TEST_OUT, 32'h0);
        check(q, 32'h0);
        bus(1, 8'h20, 32'h38);
        bus(1, 8'h40, 32'h2C);
        bus(1, 8'h44, 32'h3B);
        bus(1, 8'h24, 32'h29);
        rm.hold(8'h03);
        repeat (3) @(posedge clk_sys_i);
        check(mark_wr_o, 16'h0408);
        rm.hold(8'h00);
        @(posedge clk_sys_i) sample_tick_i <= 1'b1;
        @(posedge clk_sys_i) sample_tick_i <= 1'b0;
        @(posedge clk_sys_i);
        check(mark_wr_o, 16'h0000);
        mark_rd_i <= 16'h0408;
        out_tick_i <= 1'b1;
        @(posedge clk_sys_i);
        out_tick_i <= 1'b0;
        // memory output no longer valid: show the inverse
        mark_rd_i <= 16'hFBF7;
        cnt(1);
        check(n, PC);
        check(gpo_o[0], 1'b1);
        conclude();
    end
endmodule // dlyg_remote_port_tb
bind dlyg_remote_port dlyg_remote_port_properties u_props (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .gpi_i(gpi_i), .cmd_o(cmd_o));
